// file: logic/gcs_cfg.sv
// Gain control and carrier sense configuration bank, top level.
// Assumes register port and receive datapath share the one clock.
//
// Summary of operation
// - Digital ceiling code N bars the N highest digital amplifier steps.
// - Digital ceiling resets to zero, all digital steps usable.
// - Front ceiling caps combined front gain, 17.1 dB below maximum at code 7.
// - Amplitude goal codes map to 24..42 dB; reset code is 3.
// - Order bit one, its reset value, cuts first amplifier first.
// - Order bit zero cuts second amplifier to minimum, then first.
// - Relative sense codes 1..3 trigger on 6, 10, 14 dB RSSI rise.
// - Absolute level is signed dB offset from goal, -7..+7, reset 0.
// - Absolute level -8 disables the absolute threshold.
// - Absolute compare uses filter amplitude as if gain were uncut.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module gcs_cfg (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData_r,
   input wire gcs_pkg::gcs_sample_t sample,
   input wire logic [2:0] digitalGainReq,
   input wire logic reduceReq,
   input wire logic [2:0] firstGain,
   input wire logic [2:0] secondGain,
   output logic [2:0] digitalGainStep_r,
   output logic [7:0] frontCutTenthDb_r,
   output logic [7:0] amplitudeGoalDb_r,
   output logic cutFirst_r,
   output logic cutSecond_r,
   output logic carrierSense_r,
   output logic irq_r
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   gcs_pkg::gcs_limits_t limits_r;
   gcs_pkg::gcs_sense_cfg_t senseCfg_r;
   gcs_pkg::gcs_events_t status_r;
   gcs_pkg::gcs_events_t mask_r;
   gcs_pkg::gcs_events_t events;
   logic [7:0] rdData_nxt;
   logic [2:0] digitalTop;
   logic [2:0] digitalGain_nxt;
   logic senseLast_r;
   logic relHit;
   logic absHit;
   logic wrLimits;
   logic wrSense;
   logic wrStatus;
   logic wrMask;

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   // Strobes are one cycle, so a decode per register is enough
   assign wrLimits = regWrite && (regAddr == gcs_pkg::GCS_OFS_LIMITS);
   assign wrSense = regWrite && (regAddr == gcs_pkg::GCS_OFS_SENSE);
   assign wrStatus = regWrite && (regAddr == gcs_pkg::GCS_OFS_IRQ_STATUS);
   assign wrMask = regWrite && (regAddr == gcs_pkg::GCS_OFS_IRQ_MASK);

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   // Limits and goal register, all bits writable
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         limits_r.digitalGainCeiling <= gcs_pkg::GCS_RST_DIG_CEIL;
         limits_r.frontGainCeiling <= gcs_pkg::GCS_RST_FRONT_CEIL;
         limits_r.amplitudeGoal <= gcs_pkg::GCS_RST_GOAL;
      end else if (wrLimits) begin
         limits_r <= regWrData;
      end
   end

   // Strategy and sense register; top bit is unused and reads zero
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         senseCfg_r.unused <= 1'b0;
         senseCfg_r.gainReduceOrder <= gcs_pkg::GCS_RST_ORDER;
         senseCfg_r.relativeSenseStep <= gcs_pkg::GCS_RST_REL_STEP;
         senseCfg_r.absoluteSenseLevel <= gcs_pkg::GCS_RST_ABS_LEVEL;
      end else if (wrSense) begin
         senseCfg_r.unused <= 1'b0;
         senseCfg_r.gainReduceOrder <= regWrData[6];
         senseCfg_r.relativeSenseStep <= regWrData[5:4];
         senseCfg_r.absoluteSenseLevel <= regWrData[3:0];
      end
   end

   // ----------------------------------------
   // Interrupt registers
   // ----------------------------------------
   // Mask keeps only the implemented event bits
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mask_r <= gcs_pkg::GCS_RST_MASK;
      end else if (wrMask) begin
         mask_r <= {5'h00, regWrData[2:0]};
      end
   end

   // Events of this cycle
   always_comb begin
      events = '0;
      events.senseRise = carrierSense_r && !senseLast_r;
      events.senseFall = !carrierSense_r && senseLast_r;
      events.digitalClamped = digitalGainReq > digitalTop;
   end

   // Sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status_r <= '0;
      end else if (wrStatus) begin
         status_r <= (status_r & ~{5'h1F, regWrData[2:0]}) | events;
      end else begin
         status_r <= status_r | events;
      end
   end

   // Level interrupt, one cycle behind the status bit
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(status_r & mask_r);
      end
   end

   // Previous carrier sense for edge events
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         senseLast_r <= 1'b0;
      end else begin
         senseLast_r <= carrierSense_r;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Unmapped offsets read zero
   always_comb begin
      rdData_nxt = 8'h00;
      unique case (regAddr)
         gcs_pkg::GCS_OFS_LIMITS: begin
            rdData_nxt = limits_r;
         end
         gcs_pkg::GCS_OFS_SENSE: begin
            rdData_nxt = {1'b0, senseCfg_r[6:0]};
         end
         gcs_pkg::GCS_OFS_IRQ_STATUS: begin
            rdData_nxt = status_r;
         end
         gcs_pkg::GCS_OFS_IRQ_MASK: begin
            rdData_nxt = mask_r;
         end
         gcs_pkg::GCS_OFS_STATE: begin
            rdData_nxt = {digitalGainStep_r, 2'b00, absHit, relHit, carrierSense_r};
         end
         default: begin
            rdData_nxt = 8'h00;
         end
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         regRdData_r <= 8'h00;
      end else if (regRead) begin
         regRdData_r <= rdData_nxt;
      end else begin
         regRdData_r <= 8'h00;
      end
   end

   // ----------------------------------------
   // Gain limits
   // ----------------------------------------
   // Highest digital step still allowed under the ceiling
   always_comb begin
      digitalTop = gcs_pkg::GCS_DIG_TOP_STEP - {1'b0, limits_r.digitalGainCeiling};
      if (digitalGainReq > digitalTop) begin
         digitalGain_nxt = digitalTop;
      end else begin
         digitalGain_nxt = digitalGainReq;
      end
   end

   // Registered limits toward the gain loop
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         digitalGainStep_r <= 3'h0;
         frontCutTenthDb_r <= 8'h00;
         amplitudeGoalDb_r <= gcs_pkg::GCS_GOAL_DB[gcs_pkg::GCS_RST_GOAL];
      end else begin
         digitalGainStep_r <= digitalGain_nxt;
         frontCutTenthDb_r <= gcs_pkg::GCS_FRONT_CUT_TENTH[limits_r.frontGainCeiling];
         amplitudeGoalDb_r <= gcs_pkg::GCS_GOAL_DB[limits_r.amplitudeGoal];
      end
   end

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   // Goal is taken from the register, not the output flop, so the
   // threshold follows a write without an extra cycle of lag
   gcs_sense senseUnit (
      .clock(clock),
      .reset_n(reset_n),
      .sample(sample),
      .relStep(senseCfg_r.relativeSenseStep),
      .absLevel(senseCfg_r.absoluteSenseLevel),
      .goalDb(gcs_pkg::GCS_GOAL_DB[limits_r.amplitudeGoal]),
      .sense_r(carrierSense_r),
      .relHit_r(relHit),
      .absHit_r(absHit)
   );

   // Front-end reduction order
   gcs_reduce reduceUnit (
      .clock(clock),
      .reset_n(reset_n),
      .order(senseCfg_r.gainReduceOrder),
      .reduceReq(reduceReq),
      .firstGain(firstGain),
      .secondGain(secondGain),
      .cutFirst_r(cutFirst_r),
      .cutSecond_r(cutSecond_r)
   );

endmodule : gcs_cfg

// file: logic/gcs_pkg.sv
// Package for the gain control and carrier sense configuration bank.
// Assumes a single 40 MHz clock and a byte-wide register port.
package gcs_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] GCS_OFS_LIMITS = 8'h1B;
   localparam logic [7:0] GCS_OFS_SENSE = 8'h1C;
   localparam logic [7:0] GCS_OFS_IRQ_STATUS = 8'h30;
   localparam logic [7:0] GCS_OFS_IRQ_MASK = 8'h31;
   localparam logic [7:0] GCS_OFS_STATE = 8'h32;

   // ----------------------------------------
   // Field layouts
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] digitalGainCeiling;
      logic [2:0] frontGainCeiling;
      logic [2:0] amplitudeGoal;
   } gcs_limits_t;

   typedef struct packed {
      logic unused;
      logic gainReduceOrder;
      logic [1:0] relativeSenseStep;
      logic [3:0] absoluteSenseLevel;
   } gcs_sense_cfg_t;

   // Interrupt status and mask layout
   typedef struct packed {
      logic [4:0] unused;
      logic digitalClamped;
      logic senseFall;
      logic senseRise;
   } gcs_events_t;

   // Measurement sample from the receive datapath
   typedef struct packed {
      logic valid;
      logic [7:0] rssiDb;
      logic [7:0] filterAmpDb;
      logic [7:0] gainCutDb;
   } gcs_sample_t;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [1:0] GCS_RST_DIG_CEIL = 2'h0;
   localparam logic [2:0] GCS_RST_FRONT_CEIL = 3'h0;
   localparam logic [2:0] GCS_RST_GOAL = 3'h3;
   localparam logic GCS_RST_ORDER = 1'b1;
   localparam logic [1:0] GCS_RST_REL_STEP = 2'h0;
   localparam logic [3:0] GCS_RST_ABS_LEVEL = 4'h0;
   localparam logic [7:0] GCS_RST_MASK = 8'h00;

   // ----------------------------------------
   // Encodings and tables
   // ----------------------------------------
   localparam logic [3:0] GCS_ABS_OFF = 4'h8;
   localparam logic [1:0] GCS_REL_OFF = 2'h0;
   localparam int GCS_DIG_STEP_W = 3;
   localparam logic [2:0] GCS_DIG_TOP_STEP = 3'h7;
   localparam logic [7:0] GCS_GOAL_DB [0:7] = '{
      8'h18, 8'h1B, 8'h1E, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2A};
   // Front cap below maximum, in tenths of a dB
   localparam logic [7:0] GCS_FRONT_CUT_TENTH [0:7] = '{
      8'h00, 8'h1A, 8'h3D, 8'h4A, 8'h5C, 8'h73, 8'h92, 8'hAB};
   localparam logic [7:0] GCS_REL_STEP_DB [0:3] = '{
      8'h00, 8'h06, 8'h0A, 8'h0E};

endpackage : gcs_pkg

// file: logic/gcs_sense.sv
// Carrier sense decision from relative and absolute thresholds.
// Assumes samples come from logic on the same clock.
`timescale 1ns/1ps
module gcs_sense (
   input wire logic clock,
   input wire logic reset_n,
   input wire gcs_pkg::gcs_sample_t sample,
   input wire logic [1:0] relStep,
   input wire logic [3:0] absLevel,
   input wire logic [7:0] goalDb,
   output logic sense_r,
   output logic relHit_r,
   output logic absHit_r
);
   logic [7:0] baseline_r;
   logic baseValid_r;
   logic [8:0] relLimit;
   logic signed [9:0] absLimit;
   logic signed [9:0] levelNoCut;
   logic relHit;
   logic absHit;

   // ----------------------------------------
   // Threshold compare
   // ----------------------------------------
   // Absolute level is the filter amplitude before any gain cut
   always_comb begin
      relLimit = {1'b0, baseline_r} + {1'b0, gcs_pkg::GCS_REL_STEP_DB[relStep]};
      absLimit = $signed({2'b00, goalDb}) + $signed({{6{absLevel[3]}}, absLevel});
      levelNoCut = $signed({2'b00, sample.filterAmpDb}) + $signed({2'b00, sample.gainCutDb});
      relHit = (relStep != gcs_pkg::GCS_REL_OFF) && baseValid_r
         && ({1'b0, sample.rssiDb} >= relLimit);
      absHit = (absLevel != gcs_pkg::GCS_ABS_OFF) && (levelNoCut >= absLimit);
   end

   // Baseline follows the quiet channel, frozen while the relative threshold is hit
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         baseline_r <= 8'h00;
         baseValid_r <= 1'b0;
      end else if (sample.valid && !relHit) begin
         baseline_r <= sample.rssiDb;
         baseValid_r <= 1'b1;
      end
   end

   // Decision held between samples
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sense_r <= 1'b0;
         relHit_r <= 1'b0;
         absHit_r <= 1'b0;
      end else if (sample.valid) begin
         sense_r <= relHit | absHit;
         relHit_r <= relHit;
         absHit_r <= absHit;
      end
   end
endmodule : gcs_sense

// file: logic/gcs_reduce.sv
// Chooses which front-end amplifier takes a gain reduction step.
// Assumes gain settings and requests come from the same clock domain.
`timescale 1ns/1ps
module gcs_reduce (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic order,
   input wire logic reduceReq,
   input wire logic [2:0] firstGain,
   input wire logic [2:0] secondGain,
   output logic cutFirst_r,
   output logic cutSecond_r
);
   logic pickFirst;

   // ----------------------------------------
   // Order of reduction
   // ----------------------------------------
   // A stage already at minimum hands the step to the other one
   always_comb begin
      if (order) begin
         pickFirst = (firstGain != 3'h0);
      end else begin
         pickFirst = (secondGain == 3'h0);
      end
   end

   // One-cycle step pulses; nothing moves when both are at minimum
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cutFirst_r <= 1'b0;
         cutSecond_r <= 1'b0;
      end else begin
         cutFirst_r <= reduceReq && pickFirst && (firstGain != 3'h0);
         cutSecond_r <= reduceReq && !pickFirst && (secondGain != 3'h0);
      end
   end
endmodule : gcs_reduce

// file: tb/gcs_cfg_assertions.sv
// Checker for the gain control and carrier sense bank.
// Assumes it is bound to gcs_cfg and sees only its ports.
`timescale 1ns/1ps
module gcs_cfg_assertions (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdData_r,
   input wire gcs_pkg::gcs_sample_t sample,
   input wire logic [2:0] digitalGainReq,
   input wire logic reduceReq,
   input wire logic [2:0] firstGain,
   input wire logic [2:0] secondGain,
   input wire logic [2:0] digitalGainStep_r,
   input wire logic [7:0] frontCutTenthDb_r,
   input wire logic [7:0] amplitudeGoalDb_r,
   input wire logic cutFirst_r,
   input wire logic cutSecond_r,
   input wire logic carrierSense_r,
   input wire logic irq_r
);
   // ----------------------------------------
   // Clocking and sequences
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   // Request held long enough for the step to settle
   sequence reqHeld;
      $stable(digitalGainReq) [*2];
   endsequence

   // Cut request where some amplifier still has gain
   sequence cutPossible;
      reduceReq && (firstGain != 3'h0 || secondGain != 3'h0);
   endsequence

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   step_ceiling_a: assert property (
      reqHeld |-> digitalGainStep_r <= digitalGainReq)
      else $error("digital step above request");
   front_table_a: assert property (
      frontCutTenthDb_r inside {8'h00, 8'h1A, 8'h3D, 8'h4A, 8'h5C, 8'h73, 8'h92, 8'hAB})
      else $error("front cap outside table");
   goal_table_a: assert property (
      amplitudeGoalDb_r inside {8'h18, 8'h1B, 8'h1E, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2A})
      else $error("amplitude goal outside table");
   cut_answer_a: assert property (
      cutPossible |=> $onehot({cutFirst_r, cutSecond_r}))
      else $error("reduce request not answered by one cut");
   cut_spent_a: assert property (
      reduceReq && (firstGain == 3'h0) != (secondGain == 3'h0)
      |=> cutFirst_r == $past(firstGain != 3'h0))
      else $error("cut went to an amplifier at minimum");
   cut_cause_a: assert property (
      (cutFirst_r || cutSecond_r) |-> $past(reduceReq))
      else $error("cut pulse without request");
   cut_minimum_a: assert property (
      cutSecond_r |-> $past(secondGain) != 3'h0)
      else $error("second cut at minimum gain");
   sense_hold_a: assert property (
      !$past(sample.valid) |-> $stable(carrierSense_r))
      else $error("carrier sense moved without sample");
endmodule : gcs_cfg_assertions

bind gcs_cfg gcs_cfg_assertions chk (.clock(clock), .reset_n(reset_n), .regAddr(regAddr),
   .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
   .regRdData_r(regRdData_r), .sample(sample), .digitalGainReq(digitalGainReq),
   .reduceReq(reduceReq), .firstGain(firstGain), .secondGain(secondGain),
   .digitalGainStep_r(digitalGainStep_r), .frontCutTenthDb_r(frontCutTenthDb_r),
   .amplitudeGoalDb_r(amplitudeGoalDb_r), .cutFirst_r(cutFirst_r),
   .cutSecond_r(cutSecond_r), .carrierSense_r(carrierSense_r), .irq_r(irq_r));

// file: tb/tb_gcs_cfg.sv
// Self-checking bench for the gain control and carrier sense bank.
// Assumes the register port answers reads one cycle later.
`timescale 1ns/1ps
module tb_gcs_cfg;
   logic clock, reset_n, regWrite, regRead, reduceReq;
   logic [7:0] regAddr, regWrData, regRdData_r, frontCutTenthDb_r, amplitudeGoalDb_r;
   gcs_pkg::gcs_sample_t sample;
   logic [2:0] digitalGainReq, firstGain, secondGain, digitalGainStep_r;
   logic cutFirst_r, cutSecond_r, carrierSense_r, irq_r;
   int n_errors = 0;
   int n_checks = 0;
   int goalDb [8] = '{24, 27, 30, 33, 36, 38, 40, 42};
   int frontTenth [8] = '{0, 26, 61, 74, 92, 115, 146, 171};
   int relDb [4] = '{0, 6, 10, 14};

   gcs_cfg dut (.clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData_r(regRdData_r), .sample(sample),
      .digitalGainReq(digitalGainReq), .reduceReq(reduceReq), .firstGain(firstGain),
      .secondGain(secondGain), .digitalGainStep_r(digitalGainStep_r),
      .frontCutTenthDb_r(frontCutTenthDb_r), .amplitudeGoalDb_r(amplitudeGoalDb_r),
      .cutFirst_r(cutFirst_r), .cutSecond_r(cutSecond_r),
      .carrierSense_r(carrierSense_r), .irq_r(irq_r));

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask : wr

   // Data stands only in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      #1 chk("read", exp, regRdData_r);
   endtask : rd

   // Outputs follow a write one edge later; two spare
   task settle;
      repeat (3) @(posedge clock);
      #1;
   endtask : settle

   task red(input logic [2:0] f, input logic [2:0] s, input logic eF, input logic eS);
      @(posedge clock);
      reduceReq <= 1'b1;
      firstGain <= f;
      secondGain <= s;
      @(posedge clock);
      reduceReq <= 1'b0;
      #1 chk("cutFirst", eF, cutFirst_r);
      chk("cutSecond", eS, cutSecond_r);
   endtask : red

   task smp(input logic [7:0] r, input logic [7:0] f, input logic [7:0] g, input logic e);
      @(posedge clock);
      sample <= '{1'b1, r, f, g};
      @(posedge clock);
      sample.valid <= 1'b0;
      #1 chk("sense", e, carrierSense_r);
   endtask : smp

   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim

   // ----------------------------------------
   // Clock, watchdog and tests
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Tests need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clock);
      n_errors++;
      end_sim();
   end

   initial begin
      {reset_n, regWrite, regRead, reduceReq, regAddr, regWrData} = '0;
      {sample, digitalGainReq, firstGain, secondGain} = '0;
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      rd(8'h1B, 8'h03);
      rd(8'h1C, 8'h40);
      rd(8'h00, 8'h00);
      chk("goal", 8'd33, amplitudeGoalDb_r);
      $display("test reset done");
      for (int c = 0; c < 8; c++) begin
         wr(8'h1B, {2'h0, c[2:0], c[2:0]});
         settle();
         chk("goal", 8'(goalDb[c]), amplitudeGoalDb_r);
         chk("front", 8'(frontTenth[c]), frontCutTenthDb_r);
         rd(8'h1B, {2'h0, c[2:0], c[2:0]});
      end
      $display("test tables done");
      // Clamp events feed the interrupt path
      @(posedge clock);
      digitalGainReq <= 3'h7;
      for (int n = 0; n < 4; n++) begin
         wr(8'h1B, {n[1:0], 6'h03});
         settle();
         chk("step", 8'(7 - n), digitalGainStep_r);
      end
      rd(8'h30, 8'h04);
      chk("irq", 1'b0, irq_r);
      wr(8'h31, 8'h04);
      settle();
      chk("irq", 1'b1, irq_r);
      @(posedge clock);
      digitalGainReq <= 3'h0;
      wr(8'h30, 8'h04);
      settle();
      chk("irq", 1'b0, irq_r);
      rd(8'h30, 8'h00);
      wr(8'h1C, 8'hFF);
      rd(8'h1C, 8'h7F);
      $display("test ceiling done");
      for (int o = 0; o < 2; o++) begin
         wr(8'h1C, {1'b0, o[0], 6'h08});
         red(3'h2, 3'h3, o[0], !o[0]);
         red(3'h0, 3'h3, 1'b0, 1'b1);
         red(3'h2, 3'h0, 1'b1, 1'b0);
         red(3'h0, 3'h0, 1'b0, 1'b0);
      end
      $display("test reduce done");
      // Goal 33 dB; cut gain counts back into the level
      wr(8'h1B, 8'h03);
      wr(8'h1C, 8'h00);
      smp(8'd0, 8'd30, 8'd3, 1'b1);
      smp(8'd0, 8'd30, 8'd2, 1'b0);
      wr(8'h1C, 8'h0F);
      smp(8'd0, 8'd30, 8'd2, 1'b1);
      wr(8'h1C, 8'h07);
      smp(8'd0, 8'd35, 8'd4, 1'b0);
      smp(8'd0, 8'd36, 8'd4, 1'b1);
      rd(8'h32, 8'h05);
      wr(8'h1C, 8'h08);
      smp(8'd0, 8'd60, 8'd60, 1'b0);
      for (int k = 1; k < 4; k++) begin
         wr(8'h1C, {2'h0, k[1:0], 4'h8});
         smp(8'd0, 8'd0, 8'd0, 1'b0);
         smp(8'(relDb[k] - 1), 8'd0, 8'd0, 1'b0);
         smp(8'(2 * relDb[k] - 1), 8'd0, 8'd0, 1'b1);
      end
      wr(8'h1C, 8'h08);
      smp(8'd0, 8'd0, 8'd0, 1'b0);
      smp(8'd60, 8'd0, 8'd0, 1'b0);
      rd(8'h30, 8'h03);
      wr(8'h31, 8'h03);
      settle();
      chk("irq", 1'b1, irq_r);
      wr(8'h30, 8'hFF);
      settle();
      chk("irq", 1'b0, irq_r);
      rd(8'h30, 8'h00);
      $display("test sense done");
      end_sim();
   end
endmodule : tb_gcs_cfg
